// ==== rtl/extended_feature_control.sv ====
/*
 * Extended feature control register: storage, model register access,
 * long mode activation and gating of the instructions the bits control.
 * Assumes the core presents paging enable, the code segment long bit and
 * the privilege level on core_clk, and that one request of each kind
 * is held for a single cycle.
 */
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [RL1] Bit 0 enables fast call and return
// [RL2] Long mode enable only permits long mode
// [RL3] Paging on with enable sets active
// [RL4] Active: compat or 64-bit by long bit
// [RL5] Inactive: legacy mode, 64-bit features off
// [RL6] Write with wrong active bit faults
// [RL7] Software preserves active bit on writes
// [RL8] Bit 11 enables no-execute protection
// [RL9] Software checks no-execute support first
// [RL10] Bit 12 zero: virt instructions undefined
// [RL11] Virtualization enable resets to zero
// [RL12] Hypervisor keeps guests off this register
// [RL13] Bit 13 enables 64-bit limit checks
// [RL14] Bit 14 skips vector regs at kernel
// [RL15] Fast save ignored outside kernel 64-bit
// [RL16] Legacy FP and control status always saved
// [RL17] Bit 15 clear: flush all upper entries
// [RL18] Bit 15 set: flush path entries only
// [RL19] Software checks flush support, tolerates staleness
// [RL20] Only privileged model register access
// [RL21] Reserved high bits and bit 9 zero
// [RL22] Bits 7 to 1 read zero
// [RL23] Everything resets to zero, legacy mode
module extended_feature_control
   import feature_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Model register access
   input wire msr_req_t msr_req,
   output var msr_rsp_t msr_rsp,
   // Core state
   input wire logic paging_enabled,
   input wire logic code_long_bit,
   input wire logic [1:0] current_privilege_level,
   // Instruction gating
   input wire op_req_t op_req,
   output var op_rsp_t op_rsp,
   // Feature levels
   output var feature_state_t features
);

   typedef struct packed {
      logic fast_fast_call_op_enable;
      logic long_mode_enable;
      logic long_mode_active;
      logic no_execute_enable;
      logic secure_virt_enable;
      logic segment_limit_check_enable;
      logic fast_state_save_enable;
      logic selective_tlb_flush_enable;
   } efe_fields_t;

   typedef struct packed {
      efe_fields_t efe;
      cpu_mode_t mode;
      logic limit_check_on;
      msr_rsp_t msr_rsp;
      op_rsp_t op_rsp;
   } state_t;

   localparam efe_fields_t EFE_RESET = '{
      fast_fast_call_op_enable: EFE_FIELD_RESET,
      long_mode_enable: EFE_FIELD_RESET,
      long_mode_active: EFE_FIELD_RESET,
      no_execute_enable: EFE_FIELD_RESET,
      secure_virt_enable: EFE_FIELD_RESET,
      segment_limit_check_enable: EFE_FIELD_RESET,
      fast_state_save_enable: EFE_FIELD_RESET,
      selective_tlb_flush_enable: EFE_FIELD_RESET
   };

   logic [1:0] rst_sync_ff;
   logic rst_n;
   state_t state_ff;
   state_t nxt_state;
   logic [63:0] read_value;
   logic addr_hit;
   logic privileged;
   logic reserved_dirty;
   logic active_mismatch;
   logic write_ok;
   logic in_long64;

   // Field map checked at elaboration: a moved field must stay inside the
   // writable low 16 bits, off the reserved bits, and on a bit of its own
   localparam int FIELD_COUNT = 8;
   localparam int FIELD_POS [FIELD_COUNT] = '{
      FAST_FAST_CALL_OP_BIT,
      LONG_MODE_EN_BIT,
      LONG_MODE_ACT_BIT,
      NO_EXEC_BIT,
      SECURE_VIRT_BIT,
      SEG_LIMIT_BIT,
      FAST_SAVE_BIT,
      SEL_FLUSH_BIT
   };

   if (DATA_W != $bits(read_value) || MBZ_HIGH_LSB >= DATA_W) begin : g_word_check
      $error("register word width does not match the field map");
   end

   for (genvar i = 0; i < FIELD_COUNT; i++) begin : g_field_check
      if (FIELD_POS[i] >= MBZ_HIGH_LSB || FIELD_POS[i] == MBZ_LOW_BIT) begin : g_reserved
         $error("field placed on a reserved bit");
      end
      if (FIELD_POS[i] > FAST_FAST_CALL_OP_BIT && FIELD_POS[i] < LONG_MODE_EN_BIT) begin : g_raz
         $error("field placed in the read-as-zero range");
      end
      for (genvar j = i + 1; j < FIELD_COUNT; j++) begin : g_pair
         if (FIELD_POS[i] == FIELD_POS[j]) begin : g_clash
            $error("two fields share one bit");
         end
      end
   end

   // Reset release through two flops; assertion stays asynchronous
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_sync_ff <= 2'h0;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_ff[1];

   // Register image as software sees it
   always_comb begin
      read_value = RESERVED_READ; // [RL22]
      read_value[FAST_FAST_CALL_OP_BIT] = state_ff.efe.fast_fast_call_op_enable;
      read_value[LONG_MODE_EN_BIT] = state_ff.efe.long_mode_enable;
      read_value[LONG_MODE_ACT_BIT] = state_ff.efe.long_mode_active;
      read_value[NO_EXEC_BIT] = state_ff.efe.no_execute_enable;
      read_value[SECURE_VIRT_BIT] = state_ff.efe.secure_virt_enable;
      read_value[SEG_LIMIT_BIT] = state_ff.efe.segment_limit_check_enable;
      read_value[FAST_SAVE_BIT] = state_ff.efe.fast_state_save_enable;
      read_value[SEL_FLUSH_BIT] = state_ff.efe.selective_tlb_flush_enable;
   end

   // Write admission checks
   always_comb begin
      addr_hit = msr_req.addr == EFE_ADDR;
      privileged = current_privilege_level == PRIV_KERNEL; // [RL20]
      // Nonzero reserved bits are refused rather than dropped silently
      reserved_dirty = (|msr_req.wdata[63:MBZ_HIGH_LSB])
         | msr_req.wdata[MBZ_LOW_BIT]; // [RL21]
      // The active bit is hardware owned; a write must echo it
      active_mismatch = msr_req.wdata[LONG_MODE_ACT_BIT]
         != state_ff.efe.long_mode_active; // [RL6] [RL7]
      write_ok = msr_req.valid & msr_req.write & addr_hit & privileged
         & !reserved_dirty & !active_mismatch;
      in_long64 = state_ff.mode == MODE_LONG64;
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_state.msr_rsp.done = 1'b0;
      nxt_state.msr_rsp.general_protection_fault = 1'b0;
      nxt_state.op_rsp = '0;

      // Model register access: answer one cycle after the request
      if (msr_req.valid) begin
         nxt_state.msr_rsp.done = 1'b1;
         if (!privileged || !addr_hit) begin
            nxt_state.msr_rsp.general_protection_fault = 1'b1; // [RL20]
            nxt_state.msr_rsp.rdata = RESERVED_READ;
         end else if (!msr_req.write) begin
            nxt_state.msr_rsp.rdata = read_value;
         end else if (!write_ok) begin
            nxt_state.msr_rsp.general_protection_fault = 1'b1; // [RL6]
            nxt_state.msr_rsp.rdata = RESERVED_READ;
         end else begin
            nxt_state.msr_rsp.rdata = RESERVED_READ;
         end
      end

      if (write_ok) begin
         nxt_state.efe.fast_fast_call_op_enable =
            msr_req.wdata[FAST_FAST_CALL_OP_BIT]; // [RL1]
         nxt_state.efe.long_mode_enable =
            msr_req.wdata[LONG_MODE_EN_BIT]; // [RL2]
         nxt_state.efe.no_execute_enable =
            msr_req.wdata[NO_EXEC_BIT]; // [RL8]
         nxt_state.efe.secure_virt_enable =
            msr_req.wdata[SECURE_VIRT_BIT]; // [RL10]
         nxt_state.efe.segment_limit_check_enable =
            msr_req.wdata[SEG_LIMIT_BIT]; // [RL13]
         nxt_state.efe.fast_state_save_enable =
            msr_req.wdata[FAST_SAVE_BIT]; // [RL14]
         nxt_state.efe.selective_tlb_flush_enable =
            msr_req.wdata[SEL_FLUSH_BIT]; // [RL17]
      end

      // Active only once paging is on as well; enable alone never activates
      nxt_state.efe.long_mode_active =
         nxt_state.efe.long_mode_enable & paging_enabled; // [RL2] [RL3]

      // Operating mode follows the active bit and the code segment
      if (!nxt_state.efe.long_mode_active) begin
         nxt_state.mode = MODE_LEGACY; // [RL5]
      end else if (code_long_bit) begin
         nxt_state.mode = MODE_LONG64; // [RL4]
      end else begin
         nxt_state.mode = MODE_COMPAT; // [RL4]
      end

      // Taken from the next values so it leaves a flop in step with the mode
      nxt_state.limit_check_on = nxt_state.efe.segment_limit_check_enable
         & (nxt_state.mode == MODE_LONG64); // [RL13]

      // Instruction gating: answer one cycle after the request
      if (op_req.valid) begin
         nxt_state.op_rsp.done = 1'b1;
         case (op_req.kind)
            OP_FAST_CALL, OP_FAST_RETURN: begin
               nxt_state.op_rsp.undefined_opcode_fault =
                  !state_ff.efe.fast_fast_call_op_enable; // [RL1]
            end
            OP_SECURE_VIRT: begin
               nxt_state.op_rsp.undefined_opcode_fault =
                  !state_ff.efe.secure_virt_enable; // [RL10]
            end
            OP_STATE_SAVE, OP_STATE_RESTORE: begin
               // Vector registers skipped only at kernel level in 64-bit
               nxt_state.op_rsp.save_vector_registers =
                  !(state_ff.efe.fast_state_save_enable & in_long64
                    & privileged); // [RL14] [RL15]
               nxt_state.op_rsp.save_legacy_fp = 1'b1; // [RL16]
               nxt_state.op_rsp.save_vector_control_status = 1'b1; // [RL16]
            end
            OP_PAGE_INVALIDATE: begin
               nxt_state.op_rsp.flush_target = 1'b1;
               nxt_state.op_rsp.flush_upper_all =
                  !state_ff.efe.selective_tlb_flush_enable; // [RL17]
               nxt_state.op_rsp.flush_upper_path =
                  state_ff.efe.selective_tlb_flush_enable; // [RL18]
            end
            default: begin
               nxt_state.op_rsp.undefined_opcode_fault = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff.efe <= EFE_RESET; // [RL11] [RL23]
         state_ff.mode <= MODE_LEGACY; // [RL23]
         state_ff.limit_check_on <= 1'b0; // [RL23]
         state_ff.msr_rsp <= '0;
         state_ff.op_rsp <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign msr_rsp = state_ff.msr_rsp;
   assign op_rsp = state_ff.op_rsp;

   // Feature levels for the rest of the core
   always_comb begin
      features.fast_fast_call_op_enable = state_ff.efe.fast_fast_call_op_enable;
      features.long_mode_enable = state_ff.efe.long_mode_enable;
      features.long_mode_active = state_ff.efe.long_mode_active;
      features.no_execute_enable = state_ff.efe.no_execute_enable; // [RL8]
      features.secure_virt_enable = state_ff.efe.secure_virt_enable;
      features.segment_limit_check_enable =
         state_ff.efe.segment_limit_check_enable;
      features.fast_state_save_enable = state_ff.efe.fast_state_save_enable;
      features.selective_tlb_flush_enable =
         state_ff.efe.selective_tlb_flush_enable;
      // Limit checks apply in 64-bit mode only
      features.segment_limit_check_on = state_ff.limit_check_on; // [RL13]
      features.cpu_mode = state_ff.mode; // [RL4] [RL5]
   end

endmodule

`default_nettype wire

// ==== rtl/extended_feature_enable_pkg.sv ====
/*
 * Shared constants and carrier types for the extended feature control
 * register. Assumes a single core clock domain and a core pipeline that
 * issues model register accesses and gated instruction requests.
 */
package feature_ctrl_pkg;

   // Model register address and data width
   localparam logic [31:0] EFE_ADDR = 32'hC000_0080;
   localparam int DATA_W = 64;

   // Field positions
   localparam int FAST_FAST_CALL_OP_BIT = 0;
   localparam int LONG_MODE_EN_BIT = 8;
   localparam int MBZ_LOW_BIT = 9;
   localparam int LONG_MODE_ACT_BIT = 10;
   localparam int NO_EXEC_BIT = 11;
   localparam int SECURE_VIRT_BIT = 12;
   localparam int SEG_LIMIT_BIT = 13;
   localparam int FAST_SAVE_BIT = 14;
   localparam int SEL_FLUSH_BIT = 15;
   localparam int MBZ_HIGH_LSB = 16;

   // Reset value, reserved-bit read value and kernel privilege level
   localparam logic EFE_FIELD_RESET = 1'b0;
   localparam logic [63:0] RESERVED_READ = 64'h0000_0000_0000_0000;
   localparam logic [1:0] PRIV_KERNEL = 2'h0;

   typedef enum logic [1:0] {
      MODE_LEGACY,
      MODE_COMPAT,
      MODE_LONG64
   } cpu_mode_t;

   typedef enum logic [2:0] {
      OP_FAST_CALL,
      OP_FAST_RETURN,
      OP_SECURE_VIRT,
      OP_STATE_SAVE,
      OP_STATE_RESTORE,
      OP_PAGE_INVALIDATE
   } op_kind_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [63:0] wdata;
   } msr_req_t;

   typedef struct packed {
      logic done;
      logic general_protection_fault;
      logic [63:0] rdata;
   } msr_rsp_t;

   typedef struct packed {
      logic valid;
      op_kind_t kind;
   } op_req_t;

   typedef struct packed {
      logic done;
      logic undefined_opcode_fault;
      logic save_vector_registers;
      logic save_legacy_fp;
      logic save_vector_control_status;
      logic flush_target;
      logic flush_upper_all;
      logic flush_upper_path;
   } op_rsp_t;

   typedef struct packed {
      logic fast_fast_call_op_enable;
      logic long_mode_enable;
      logic long_mode_active;
      logic no_execute_enable;
      logic secure_virt_enable;
      logic segment_limit_check_enable;
      logic fast_state_save_enable;
      logic selective_tlb_flush_enable;
      logic segment_limit_check_on;
      cpu_mode_t cpu_mode;
   } feature_state_t;

endpackage

// ==== bench/efc_sva.sv ====
/*
 * Checker for the extended feature control register.
 * Sees only the top module's ports; bound from the bench top file.
 */
`timescale 1ns/100ps
`default_nettype none
module efc_sva
   import feature_ctrl_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register access
   input wire msr_req_t msr_req,
   input wire msr_rsp_t msr_rsp,
   // Core state
   input wire logic paging_enabled,
   input wire logic code_long_bit,
   input wire logic [1:0] current_privilege_level,
   // Gating and levels
   input wire op_req_t op_req,
   input wire op_rsp_t op_rsp,
   input wire feature_state_t features
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_op(op_kind_t k);
      op_req.valid && op_req.kind == k;
   endsequence
   sequence s_wr;
      msr_req.valid && msr_req.write && msr_req.addr == EFE_ADDR;
   endsequence
   chk_answer_slot: assert property (msr_req.valid |=> msr_rsp.done)
      else $error("access not answered");
   chk_priv_refused: assert property (msr_req.valid && current_privilege_level != PRIV_KERNEL
      |=> msr_rsp.general_protection_fault)
      else $error("unprivileged access taken");
   chk_active_kept: assert property (s_wr ##0 msr_req.wdata[10] != features.long_mode_active
      |=> msr_rsp.general_protection_fault)
      else $error("active bit change taken");
   chk_activation: assert property (features.long_mode_active ==
      (features.long_mode_enable && $past(paging_enabled)))
      else $error("active bit wrong");
   chk_legacy_mode: assert property (!features.long_mode_active
      |-> features.cpu_mode == MODE_LEGACY)
      else $error("not legacy");
   chk_long_mode: assert property (features.long_mode_active |-> features.cpu_mode ==
      ($past(code_long_bit) ? MODE_LONG64 : MODE_COMPAT))
      else $error("long sub-mode wrong");
   chk_virt_gate: assert property (s_op(OP_SECURE_VIRT) ##0 !features.secure_virt_enable
      |=> op_rsp.undefined_opcode_fault)
      else $error("virt op not faulted");
   chk_save_fixed: assert property (s_op(OP_STATE_SAVE) or s_op(OP_STATE_RESTORE)
      |=> op_rsp.save_legacy_fp && op_rsp.save_vector_control_status)
      else $error("fixed state skipped");
   chk_fast_save: assert property (s_op(OP_STATE_SAVE) ##0 (features.fast_state_save_enable
      && features.cpu_mode == MODE_LONG64 && current_privilege_level == PRIV_KERNEL)
      |=> !op_rsp.save_vector_registers)
      else $error("vector regs saved");
   chk_flush_scope: assert property (s_op(OP_PAGE_INVALIDATE) |=> op_rsp.flush_target
      && op_rsp.flush_upper_path == $past(features.selective_tlb_flush_enable)
      && op_rsp.flush_upper_all != op_rsp.flush_upper_path)
      else $error("flush scope wrong");
   chk_limit_check: assert property (features.segment_limit_check_on ==
      (features.segment_limit_check_enable && features.cpu_mode == MODE_LONG64))
      else $error("limit check level wrong");
endmodule
`default_nettype wire

// ==== bench/tb.sv ====
/*
 * Bench top for the extended feature control register.
 * Drives every port itself; expected answers wait in queues.
 */
`timescale 1ns/100ps
`default_nettype none
module tb
   import feature_ctrl_pkg::*;
;
   logic core_clk, reset_n, paging_enabled, code_long_bit;
   logic [1:0] current_privilege_level;
   msr_req_t msr_req;
   msr_rsp_t msr_rsp;
   op_req_t op_req;
   op_rsp_t op_rsp;
   feature_state_t features;
   logic [63:0] img;
   logic [64:0] mq[$];
   op_rsp_t oq[$];
   int bad_count = 0;
   int tests_run = 0;
   extended_feature_control extended_feature_control_i (.core_clk(core_clk),
      .reset_n(reset_n), .msr_req(msr_req), .msr_rsp(msr_rsp),
      .paging_enabled(paging_enabled), .code_long_bit(code_long_bit),
      .current_privilege_level(current_privilege_level), .op_req(op_req),
      .op_rsp(op_rsp), .features(features));
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic fail(input string m);
      $display("[FAIL] %0t %s", $time, m);
      bad_count++;
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Sampled mid-cycle so registered answers have settled
   always @(negedge core_clk) begin
      if (msr_rsp.done === 1'b1) begin
         tests_run++;
         if (mq.size() == 0 || {msr_rsp.general_protection_fault, msr_rsp.rdata} !== mq.pop_front()) begin
            fail("access answer");
         end
      end
      if (op_rsp.done === 1'b1) begin
         tests_run++;
         if (oq.size() == 0 || op_rsp !== oq.pop_front()) begin
            fail("gated op answer");
         end
      end
   end
   task automatic msr(input logic w, input logic [31:0] a, input logic [63:0] d, input logic [1:0] c);
      logic f;
      f = c != PRIV_KERNEL || a != EFE_ADDR || (w && (d[63:16] != 0 || d[9] || d[10] != img[10]));
      @(posedge core_clk);
      msr_req <= '{1'b1, w, a, d};
      current_privilege_level <= c;
      mq.push_back({f, (f || w) ? 64'h0 : img});
      if (w && !f) begin
         img = (d & 64'h0000_0000_0000_f901) | {53'h0, d[8] & paging_enabled, 10'h0};
      end
      @(posedge core_clk);
      msr_req.valid <= 1'b0;
      // Spare cycle lets the active bit settle before the next access
      @(posedge core_clk);
   endtask
   task automatic op(input op_kind_t k, input logic [1:0] c);
      op_rsp_t e;
      e = '0;
      e.done = 1'b1;
      case (k)
         OP_FAST_CALL, OP_FAST_RETURN: e.undefined_opcode_fault = !img[0];
         OP_SECURE_VIRT: e.undefined_opcode_fault = !img[12];
         OP_PAGE_INVALIDATE: begin
            e.flush_target = 1'b1;
            e.flush_upper_all = !img[15];
            e.flush_upper_path = img[15];
         end
         OP_STATE_SAVE, OP_STATE_RESTORE: begin
            e.save_vector_registers = !(img[14] && img[10] && code_long_bit && c == PRIV_KERNEL);
            e.save_legacy_fp = 1'b1;
            e.save_vector_control_status = 1'b1;
         end
         // Unassigned kind codes must fault
         default: e.undefined_opcode_fault = 1'b1;
      endcase
      @(posedge core_clk);
      op_req <= '{1'b1, k};
      current_privilege_level <= c;
      oq.push_back(e);
      @(posedge core_clk);
      op_req.valid <= 1'b0;
   endtask
   task automatic all_ops(input logic [1:0] c);
      for (int k = 0; k < 8; k++) begin
         op(op_kind_t'(k), c);
      end
   endtask
   task automatic levels();
      cpu_mode_t m;
      m = !img[10] ? MODE_LEGACY : (code_long_bit ? MODE_LONG64 : MODE_COMPAT);
      tests_run++;
      if (features !== {img[0], img[8], img[10], img[11], img[12], img[13], img[14], img[15],
            img[13] && m == MODE_LONG64, m}) begin
         fail("feature levels");
      end
   endtask
   initial begin
      #100000;
      fail("timeout");
      print_verdict();
   end
   initial begin
      reset_n = 1'b0;
      paging_enabled = 1'b0;
      code_long_bit = 1'b0;
      current_privilege_level = 2'h0;
      msr_req = '0;
      op_req = '0;
      img = '0;
      void'($urandom(43));
      repeat (5) @(posedge core_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      msr(1'b0, EFE_ADDR, 64'h0, 2'h0);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_f9ff, 2'h0);
      msr(1'b0, EFE_ADDR, 64'h0, 2'h0);
      levels();
      all_ops(2'h0);
      paging_enabled <= 1'b1;
      code_long_bit <= 1'b1;
      repeat (2) @(posedge core_clk);
      img[10] = 1'b1;
      levels();
      msr(1'b0, EFE_ADDR, 64'h0, 2'h0);
      all_ops(2'h0);
      op(OP_STATE_RESTORE, 2'h3);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_0100, 2'h0);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_0700, 2'h0);
      msr(1'b1, EFE_ADDR, {$urandom, $urandom} | 64'h0000_0000_0001_0400, 2'h0);
      msr(1'b0, EFE_ADDR, 64'h0, 2'h3);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_0400, 2'h3);
      msr(1'b0, EFE_ADDR + 32'h1, 64'h0, 2'h0);
      msr(1'b0, EFE_ADDR, 64'h0, 2'h0);
      code_long_bit <= 1'b0;
      repeat (2) @(posedge core_clk);
      op(OP_STATE_SAVE, 2'h0);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_0400, 2'h0);
      levels();
      all_ops(2'h0);
      msr(1'b1, EFE_ADDR, 64'h0000_0000_0000_1101, 2'h0);
      reset_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      reset_n <= 1'b1;
      img = '0;
      repeat (3) @(posedge core_clk);
      levels();
      msr(1'b0, EFE_ADDR, 64'h0, 2'h0);
      for (int i = 0; i < 20 && (mq.size() != 0 || oq.size() != 0); i++) begin
         @(posedge core_clk);
      end
      if (mq.size() != 0 || oq.size() != 0) begin
         fail("answer missing");
      end
      print_verdict();
   end
endmodule
bind extended_feature_control efc_sva efc_sva_i (.core_clk(core_clk), .reset_n(reset_n),
   .msr_req(msr_req), .msr_rsp(msr_rsp), .paging_enabled(paging_enabled),
   .code_long_bit(code_long_bit), .current_privilege_level(current_privilege_level),
   .op_req(op_req), .op_rsp(op_rsp), .features(features));
`default_nettype wire
